// File: core/rsx_exec.sv
`timescale 1ns/1ns
// What this block does
// - Rotate-left opcode shifts register left, carry into bit 0, bit 7 to carry.
// - Rotate-right opcode shifts right, carry into bit 7, bit 0 to carry.
// - Seven-bit register address; d=0 writes accumulator, d=1 writes register back.
// - Standby opcode enters stop mode and updates expiry and sleep flags.
// - Subtract opcode computes register minus accumulator, updates carry, half-carry, zero.
// - Nibble-exchange opcode swaps register halves, flags untouched.
// - Zero-test opcode writes nothing, sets Z when register is zero.
// - Literal XOR opcode xors accumulator with literal, updates Z.
// - Register XOR opcode xors accumulator with register to destination, updates Z.
module rsx_exec (
  // Clock and reset
  mclk,
  rst,
  // Instruction and operands
  instr_valid,
  instr,
  acc_in,
  reg_in,
  carry_in,
  // Register file address
  reg_addr,
  // Write-back
  acc_we,
  reg_we,
  reg_waddr,
  result,
  c_we,
  c_out,
  dc_we,
  dc_out,
  z_we,
  z_out,
  // Power state and accumulator shadow
  stop_req,
  expiry_indicator,
  sleep_entered_flag,
  acc_q
);
  input  wire logic        mclk;
  input  wire logic        rst;
  input  wire logic        instr_valid;
  input  wire logic [13:0] instr;
  input  wire logic [7:0]  acc_in;
  input  wire logic [7:0]  reg_in;
  input  wire logic        carry_in;
  output logic      [6:0]  reg_addr;
  output logic             acc_we;
  output logic             reg_we;
  output logic      [6:0]  reg_waddr;
  output logic      [7:0]  result;
  output logic             c_we;
  output logic             c_out;
  output logic             dc_we;
  output logic             dc_out;
  output logic             z_we;
  output logic             z_out;
  output logic             stop_req;
  output logic             expiry_indicator;
  output logic             sleep_entered_flag;
  output logic      [7:0]  acc_q;

  // ****************************************************************
  // Decode
  // ****************************************************************
  // Classify an opcode into its one-hot operation
  function automatic rsx_pkg::rsx_op_e decode(input logic [13:0] op);
    logic [5:0] hi;
    hi = op[13:rsx_pkg::HI_LSB];
    decode = rsx_pkg::RSX_NONE;
    if (hi == rsx_pkg::OP_ROTL_HI) decode = rsx_pkg::RSX_ROTL;
    if (hi == rsx_pkg::OP_ROTR_HI) decode = rsx_pkg::RSX_ROTR;
    if (hi == rsx_pkg::OP_SUB_HI) decode = rsx_pkg::RSX_SUB;
    if (hi == rsx_pkg::OP_SWP_HI) decode = rsx_pkg::RSX_SWP;
    if (hi == rsx_pkg::OP_TST_HI && op[rsx_pkg::D_BIT]) decode = rsx_pkg::RSX_TST;
    if (hi == rsx_pkg::OP_XLW_HI) decode = rsx_pkg::RSX_XLW;
    if (hi == rsx_pkg::OP_XWF_HI) decode = rsx_pkg::RSX_XWF;
  endfunction

  rsx_pkg::rsx_op_e op;
  logic             dest_reg;
  logic [8:0]       diff;
  logic [4:0]       diff_lo;

  assign op       = instr_valid ? decode(instr) : rsx_pkg::RSX_NONE;
  assign reg_addr = instr[6:0];
  assign dest_reg = instr[rsx_pkg::D_BIT];

  assign diff    = {1'b0, reg_in} + {1'b0, ~acc_in} + 9'h001;
  assign diff_lo = {1'b0, reg_in[3:0]} + {1'b0, ~acc_in[3:0]} + 5'h01;

  rsx_wb_if wb ();

  // ****************************************************************
  // Execute
  // ****************************************************************
  always_comb begin
    wb.acc_we = 1'b0;
    wb.reg_we = 1'b0;
    wb.addr   = reg_addr;
    wb.data   = 8'h00;
    wb.c_we   = 1'b0;
    wb.c_val  = 1'b0;
    wb.dc_we  = 1'b0;
    wb.dc_val = 1'b0;
    wb.z_we   = 1'b0;
    wb.z_val  = 1'b0;
    wb.stop   = 1'b0;
    unique case (op)
      rsx_pkg::RSX_ROTL: begin
        wb.data  = {reg_in[6:0], carry_in};
        wb.c_we  = 1'b1;
        wb.c_val = reg_in[7];
      end
      rsx_pkg::RSX_ROTR: begin
        wb.data  = {carry_in, reg_in[7:1]};
        wb.c_we  = 1'b1;
        wb.c_val = reg_in[0];
      end
      rsx_pkg::RSX_SUB: begin
        wb.data   = diff[7:0];
        wb.c_we   = 1'b1;
        wb.c_val  = diff[8];
        wb.dc_we  = 1'b1;
        wb.dc_val = diff_lo[4];
        wb.z_we   = 1'b1;
        wb.z_val  = (diff[7:0] == 8'h00);
      end
      rsx_pkg::RSX_SWP: begin
        wb.data = {reg_in[3:0], reg_in[7:4]};
      end
      rsx_pkg::RSX_TST: begin
        wb.z_we  = 1'b1;
        wb.z_val = (reg_in == 8'h00);
      end
      rsx_pkg::RSX_XLW: begin
        wb.data  = acc_in ^ instr[7:0];
        wb.z_we  = 1'b1;
        wb.z_val = ((acc_in ^ instr[7:0]) == 8'h00);
      end
      rsx_pkg::RSX_XWF: begin
        wb.data  = acc_in ^ reg_in;
        wb.z_we  = 1'b1;
        wb.z_val = ((acc_in ^ reg_in) == 8'h00);
      end
      rsx_pkg::RSX_NONE: begin
        wb.data = 8'h00;
      end
      default: begin
        wb.data = 8'h00;
      end
    endcase
    if (op == rsx_pkg::RSX_XLW) begin
      wb.acc_we = 1'b1;
    end else if (op inside {rsx_pkg::RSX_ROTL, rsx_pkg::RSX_ROTR, rsx_pkg::RSX_SUB,
                            rsx_pkg::RSX_SWP, rsx_pkg::RSX_XWF}) begin
      wb.acc_we = ~dest_reg;
      wb.reg_we = dest_reg;
    end
    wb.stop = instr_valid && (instr == rsx_pkg::OP_STOP);
  end

  rsx_wb_reg u_wb (
    .mclk     (mclk),
    .rst      (rst),
    .wb       (wb),
    .acc_we_q (acc_we),
    .reg_we_q (reg_we),
    .addr_q   (reg_waddr),
    .data_q   (result),
    .c_we_q   (c_we),
    .c_val_q  (c_out),
    .dc_we_q  (dc_we),
    .dc_val_q (dc_out),
    .z_we_q   (z_we),
    .z_val_q  (z_out),
    .stop_q   (stop_req)
  );

  // ****************************************************************
  // Power flags and accumulator shadow
  // ****************************************************************
  typedef struct packed {
    logic       exp_f;
    logic       slp_f;
    logic [7:0] acc;
  } rsx_st_s;

  rsx_st_s s_d;
  rsx_st_s s_q;

  // Flags idle at one after reset; standby clears sleep flag, sets expiry
  always_comb begin
    s_d = s_q;
    if (wb.stop) begin
      s_d.exp_f = 1'b1;
      s_d.slp_f = 1'b0;
    end
    if (wb.acc_we) begin
      s_d.acc = wb.data;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_q <= '{rsx_pkg::PWR_FLAG_RST, rsx_pkg::PWR_FLAG_RST, rsx_pkg::ACC_RST};
    end else begin
      s_q <= s_d;
    end
  end

  assign expiry_indicator   = s_q.exp_f;
  assign sleep_entered_flag = s_q.slp_f;
  assign acc_q              = s_q.acc;

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_rot_left;
    instr_valid && instr[13:8] == rsx_pkg::OP_ROTL_HI;
  endsequence

  a_rotate_left: assert property (@(posedge mclk) disable iff (rst)
    s_rot_left |=> c_we && c_out == $past(reg_in[7]) && result[0] == $past(carry_in))
    else $error("rotate left wrong");
  a_rotate_right: assert property (@(posedge mclk) disable iff (rst)
    instr_valid && instr[13:8] == rsx_pkg::OP_ROTR_HI |=>
    c_out == $past(reg_in[0]) && result[7] == $past(carry_in) && !z_we && !dc_we)
    else $error("rotate right wrong");
  a_dest_select: assert property (@(posedge mclk) disable iff (rst)
    instr_valid && instr[13:8] == rsx_pkg::OP_XWF_HI |=>
    reg_we == $past(instr[7]) && acc_we == !$past(instr[7]))
    else $error("destination wrong");
  a_stop_entry: assert property (@(posedge mclk) disable iff (rst)
    instr_valid && instr == rsx_pkg::OP_STOP |=>
    stop_req && expiry_indicator ##1 !sleep_entered_flag)
    else $error("stop entry wrong");
  a_sub_result: assert property (@(posedge mclk) disable iff (rst)
    instr_valid && instr[13:8] == rsx_pkg::OP_SUB_HI |=>
    result == $past(reg_in) - $past(acc_in) && dc_we && z_we)
    else $error("subtract wrong");
  a_swap_flags: assert property (@(posedge mclk) disable iff (rst)
    instr_valid && instr[13:8] == rsx_pkg::OP_SWP_HI |=>
    !c_we && !z_we && result == {$past(reg_in[3:0]), $past(reg_in[7:4])})
    else $error("swap wrong");
  a_zero_test: assert property (@(posedge mclk) disable iff (rst)
    instr_valid && instr[13:7] == {rsx_pkg::OP_TST_HI, 1'b1} |=>
    !acc_we && !reg_we && z_out == ($past(reg_in) == 8'h00))
    else $error("zero test wrong");
  a_xor_literal: assert property (@(posedge mclk) disable iff (rst)
    instr_valid && instr[13:8] == rsx_pkg::OP_XLW_HI |=>
    acc_we && result == ($past(acc_in) ^ $past(instr[7:0])))
    else $error("literal xor wrong");
  a_xor_reg: assert property (@(posedge mclk) disable iff (rst)
    instr_valid && instr[13:8] == rsx_pkg::OP_XWF_HI |=>
    result == ($past(acc_in) ^ $past(reg_in)) && z_we && z_out == (result == 8'h00))
    else $error("register xor wrong");
  a_sub_carry: assert property (@(posedge mclk) disable iff (rst)
    instr_valid && instr[13:8] == rsx_pkg::OP_SUB_HI |=>
    c_out == ($past(reg_in) >= $past(acc_in)))
    else $error("subtract carry wrong");

endmodule

// File: core/rsx_pkg.sv
package rsx_pkg;

  // ****************************************************************
  // Opcode fields
  // ****************************************************************
  localparam int OP_W   = 14;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;

  // Upper six opcode bits for each instruction group
  localparam logic [5:0] OP_ROTL_HI = 6'h0D;  // 00 1101
  localparam logic [5:0] OP_ROTR_HI = 6'h0C;  // 00 1100
  localparam logic [5:0] OP_SUB_HI  = 6'h02;  // 00 0010
  localparam logic [5:0] OP_SWP_HI  = 6'h0E;  // 00 1110
  localparam logic [5:0] OP_TST_HI  = 6'h08;  // 00 1000, d must be 1
  localparam logic [5:0] OP_XLW_HI  = 6'h1D;  // 01 1101
  localparam logic [5:0] OP_XWF_HI  = 6'h06;  // 00 0110
  localparam logic [13:0] OP_STOP   = 14'h1E03;

  // Field positions
  localparam int D_BIT   = 7;
  localparam int HI_LSB  = 8;

  // Reset values
  localparam logic [7:0] ACC_RST = 8'h00;
  // Expiry and sleep flags both idle high after reset
  localparam logic       PWR_FLAG_RST = 1'b1;

  // ****************************************************************
  // Operation codes, one-hot
  // ****************************************************************
  typedef enum logic [7:0] {
    RSX_NONE = 8'b0000_0001,
    RSX_ROTL = 8'b0000_0010,
    RSX_ROTR = 8'b0000_0100,
    RSX_SUB  = 8'b0000_1000,
    RSX_SWP  = 8'b0001_0000,
    RSX_TST  = 8'b0010_0000,
    RSX_XLW  = 8'b0100_0000,
    RSX_XWF  = 8'b1000_0000
  } rsx_op_e;

endpackage

// File: core/rsx_wb_if.sv
`timescale 1ns/1ns
// Write-back bundle from the decoder to the result register stage
interface rsx_wb_if;
  logic       acc_we;
  logic       reg_we;
  logic [6:0] addr;
  logic [7:0] data;
  logic       c_we;
  logic       c_val;
  logic       dc_we;
  logic       dc_val;
  logic       z_we;
  logic       z_val;
  logic       stop;
  modport src (output acc_we, reg_we, addr, data, c_we, c_val, dc_we, dc_val, z_we, z_val, stop);
  modport dst (input  acc_we, reg_we, addr, data, c_we, c_val, dc_we, dc_val, z_we, z_val, stop);
endinterface

// File: core/rsx_wb_reg.sv
`timescale 1ns/1ns
// Registers the decoded write-back so every write-back output of the top is a flop
module rsx_wb_reg (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // Decoded write-back in
  rsx_wb_if.dst     wb,
  // Registered write-back out
  output logic       acc_we_q,
  output logic       reg_we_q,
  output logic [6:0] addr_q,
  output logic [7:0] data_q,
  output logic       c_we_q,
  output logic       c_val_q,
  output logic       dc_we_q,
  output logic       dc_val_q,
  output logic       z_we_q,
  output logic       z_val_q,
  output logic       stop_q
);

  typedef struct packed {
    logic       acc_we;
    logic       reg_we;
    logic [6:0] addr;
    logic [7:0] data;
    logic       c_we;
    logic       c_val;
    logic       dc_we;
    logic       dc_val;
    logic       z_we;
    logic       z_val;
    logic       stop;
  } rsx_wb_s;

  rsx_wb_s st_d;
  rsx_wb_s st_q;

  // Copy the bundle into the next state
  always_comb begin
    st_d = '{wb.acc_we, wb.reg_we, wb.addr, wb.data, wb.c_we, wb.c_val,
             wb.dc_we, wb.dc_val, wb.z_we, wb.z_val, wb.stop};
  end

  // Strobes clear on reset so no spurious write follows it
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign acc_we_q = st_q.acc_we;
  assign reg_we_q = st_q.reg_we;
  assign addr_q   = st_q.addr;
  assign data_q   = st_q.data;
  assign c_we_q   = st_q.c_we;
  assign c_val_q  = st_q.c_val;
  assign dc_we_q  = st_q.dc_we;
  assign dc_val_q = st_q.dc_val;
  assign z_we_q   = st_q.z_we;
  assign z_val_q  = st_q.z_val;
  assign stop_q   = st_q.stop;

endmodule

// File: sim/tb_rotate_subtract_xor_ops.sv
`timescale 1ns/1ns
module tb_rotate_subtract_xor_ops;
  // ****************************************************************
  // Expected result of one instruction
  // ****************************************************************
  typedef struct packed {
    logic       acc_we;
    logic       reg_we;
    logic [7:0] res;
    logic       c_we;
    logic       c;
    logic       dc_we;
    logic       dc;
    logic       z_we;
    logic       z;
    logic       stop;
    logic       zt;
  } rsx_exp_s;

  logic        mclk;
  logic        rst;
  logic        instr_valid;
  logic [13:0] instr;
  logic [7:0]  acc_in;
  logic [7:0]  reg_in;
  logic        carry_in;
  logic [6:0]  reg_addr;
  logic        acc_we;
  logic        reg_we;
  logic [6:0]  reg_waddr;
  logic [7:0]  result;
  logic        c_we;
  logic        c_out;
  logic        dc_we;
  logic        dc_out;
  logic        z_we;
  logic        z_out;
  logic        stop_req;
  logic        expiry_indicator;
  logic        sleep_entered_flag;
  logic [7:0]  acc_q;
  int          err_count;
  int          num_checks;
  int          seed;
  logic        taken;
  logic        rst_s;
  logic        exp_sleep;
  logic [7:0]  exp_acc;
  logic [6:0]  addr_q[$];
  rsx_exp_s    expq[$];

  rsx_exec DUT (
    .mclk(mclk), .rst(rst), .instr_valid(instr_valid), .instr(instr), .acc_in(acc_in),
    .reg_in(reg_in), .carry_in(carry_in), .reg_addr(reg_addr), .acc_we(acc_we),
    .reg_we(reg_we), .reg_waddr(reg_waddr), .result(result), .c_we(c_we), .c_out(c_out),
    .dc_we(dc_we), .dc_out(dc_out), .z_we(z_we), .z_out(z_out), .stop_req(stop_req),
    .expiry_indicator(expiry_indicator), .sleep_entered_flag(sleep_entered_flag),
    .acc_q(acc_q)
  );

  // Free-running 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic check(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Reference behaviour; only the opcodes of this group produce strobes
  function automatic rsx_exp_s model(input logic [13:0] op, input logic [7:0] a,
                                     input logic [7:0] r, input logic cin);
    rsx_exp_s e;
    e = '0;
    e.acc_we = !op[7];
    e.reg_we = op[7];
    case (op[13:8])
      rsx_pkg::OP_ROTL_HI: begin
        e.res = {r[6:0], cin};
        e.c_we = 1'b1;
        e.c = r[7];
      end
      rsx_pkg::OP_ROTR_HI: begin
        e.res = {cin, r[7:1]};
        e.c_we = 1'b1;
        e.c = r[0];
      end
      rsx_pkg::OP_SUB_HI: begin
        e.res = r - a;
        e.c_we = 1'b1;
        e.c = r >= a;
        e.dc_we = 1'b1;
        e.dc = r[3:0] >= a[3:0];
        e.z_we = 1'b1;
      end
      rsx_pkg::OP_SWP_HI: e.res = {r[3:0], r[7:4]};
      rsx_pkg::OP_XWF_HI: begin
        e.res = a ^ r;
        e.z_we = 1'b1;
      end
      rsx_pkg::OP_XLW_HI: begin
        e.res = a ^ op[7:0];
        e.acc_we = 1'b1;
        e.reg_we = 1'b0;
        e.z_we = 1'b1;
      end
      default: begin
        e.acc_we = 1'b0;
        e.reg_we = 1'b0;
        e.zt = (op[13:7] == {rsx_pkg::OP_TST_HI, 1'b1});
        e.z = (r == 8'h00);
        e.stop = (op == rsx_pkg::OP_STOP);
      end
    endcase
    e.z = e.z_we ? (e.res == 8'h00) : e.z;
    return e;
  endfunction

  // Inputs change on the falling edge, the note goes into the queue with them
  task automatic issue(input logic [13:0] op, input logic [7:0] a, input logic [7:0] r,
                       input logic cin);
    @(negedge mclk);
    instr_valid = 1'b1;
    instr = op;
    acc_in = a;
    reg_in = r;
    carry_in = cin;
    expq.push_back(model(op, a, r, cin));
    addr_q.push_back(op[6:0]);
    #1;
    check(reg_addr === op[6:0], "read address wrong");
  endtask

  task automatic idle(input int n);
    repeat (n) begin
      @(negedge mclk);
      instr_valid = 1'b0;
    end
  endtask

  // ****************************************************************
  // Output watcher: one queued note per instruction taken
  // ****************************************************************
  always @(posedge mclk) begin
    taken = instr_valid && !rst;
    rst_s = rst;
  end

  always @(negedge mclk) begin
    rsx_exp_s e;
    logic [6:0] wa;
    if (rst_s === 1'b1) begin
      expq.delete();
      addr_q.delete();
      exp_sleep = 1'b1;
      exp_acc = rsx_pkg::ACC_RST;
      check({acc_we, reg_we, c_we, dc_we, z_we, stop_req} === 6'b0, "strobe in reset");
      check({expiry_indicator, sleep_entered_flag, acc_q} === 10'h300, "reset state");
    end else if (taken === 1'b1 && expq.size() > 0) begin
      e = expq.pop_front();
      wa = addr_q.pop_front();
      check({acc_we, reg_we} === {e.acc_we, e.reg_we}, "destination");
      if (e.reg_we) check(reg_waddr === wa, "write address");
      // Result of rotate, subtract, swap and both xors
      if (e.acc_we | e.reg_we) check(result === e.res, "result");
      check(c_we === e.c_we && (!e.c_we || c_out === e.c), "carry");
      check(dc_we === e.dc_we && (!e.dc_we || dc_out === e.dc), "half carry");
      if (e.zt) check(e.z === (z_we === 1'b1 && z_out === 1'b1), "zero test");
      else check(z_we === e.z_we && (!e.z_we || z_out === e.z), "zero");
      check(stop_req === e.stop, "standby strobe");
      if (e.stop) exp_sleep = 1'b0;
      check({expiry_indicator, sleep_entered_flag} === {1'b1, exp_sleep}, "power flags");
      // Shadow follows every accumulator write and nothing else
      if (e.acc_we) exp_acc = e.res;
      check(acc_q === exp_acc, "accumulator shadow");
    end else begin
      check({acc_we, reg_we, c_we, dc_we, z_we, stop_req} === 6'b0, "stray strobe");
    end
  end

  // Hang guard
  initial begin
    for (int i = 0; i < 20000; i++) @(posedge mclk);
    err_count++;
    $display("[ERR] %0t run did not finish", $time);
    close_out();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    logic [5:0] hi_tab[10];
    logic [13:0] op;
    err_count = 0;
    num_checks = 0;
    seed = 32'hc4bf_8f07;
    hi_tab = '{6'h0D, 6'h0C, 6'h02, 6'h0E, 6'h08, 6'h1D, 6'h06, 6'h01, 6'h1E, 6'h3F};
    rst = 1'b1;
    instr_valid = 1'b0;
    instr = 14'h0000;
    acc_in = 8'h00;
    reg_in = 8'h00;
    carry_in = 1'b0;
    exp_sleep = 1'b1;
    exp_acc = rsx_pkg::ACC_RST;
    repeat (5) @(negedge mclk);
    rst = 1'b0;
    issue(14'h0D85, 8'h00, 8'hE6, 1'b0);
    issue(14'h0D05, 8'h00, 8'h66, 1'b1);
    issue(14'h0C05, 8'h00, 8'hE6, 1'b0);
    issue(14'h0CFF, 8'h00, 8'hE7, 1'b1);
    idle(1);
    $display("test rotate done");
    issue(14'h0285, 8'h02, 8'h03, 1'b0);
    issue(14'h0285, 8'h02, 8'h02, 1'b0);
    issue(14'h0200, 8'h02, 8'h01, 1'b1);
    issue(14'h0200, 8'h01, 8'h10, 1'b0);
    issue(14'h0E05, 8'h00, 8'hA5, 1'b0);
    issue(14'h0885, 8'h11, 8'h00, 1'b0);
    issue(14'h0885, 8'h00, 8'h40, 1'b0);
    issue(14'h0805, 8'h00, 8'h00, 1'b0);
    issue(14'h1DAF, 8'hB5, 8'h00, 1'b0);
    issue(14'h1D3C, 8'h3C, 8'h00, 1'b0);
    issue(14'h0685, 8'hB5, 8'hAF, 1'b0);
    issue(14'h0600, 8'h5A, 8'h5A, 1'b0);
    idle(1);
    $display("test arithmetic done");
    issue(14'h1E04, 8'h00, 8'h00, 1'b0);
    issue(rsx_pkg::OP_STOP, 8'h00, 8'h00, 1'b0);
    idle(2);
    rst = 1'b1;
    idle(2);
    rst = 1'b0;
    $display("test standby done");
    for (int i = 0; i < 400; i++) begin
      op = 14'($random(seed));
      op[13:8] = hi_tab[i % 10];
      if (i % 37 == 0) op = rsx_pkg::OP_STOP;
      issue(op, 8'($random(seed)), 8'($random(seed)), 1'($random(seed)));
      if (i % 9 == 0) idle(1);
    end
    idle(3);
    check(expq.size() == 0, "results missing");
    $display("test random done");
    close_out();
  end
endmodule
